// *** design/atd_core.sv ***
`include "atd_defines.svh"

// What this block does
// - Store-flip XORs immediate into row pointer
// - Memory write uses old pointer first
// - Opcode 216h copies A to clock control
// - Opcode 2AAh copies A bit0 to port
// - Opcode 235h loads B:A into divider pair
// - Divider counter itself loaded immediately too
// - Opcode 22Dh copies A to pull-up first
// - Opcode 22Eh copies A to pull-up second
// - Opcode 23Fh loads B:A into timer reload
module atd_core #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic INSTR_VALID,
  input wire logic [9:0] INSTR,
  input wire logic [3:0] ACC,
  input wire logic [3:0] REG_B,
  input wire logic [3:0] ROW_IN,
  input wire logic [3:0] COL_IN,
  input wire logic ROW_LOAD,
  output atd_pkg::atd_mem_wr_t MEM_WR,
  output logic [3:0] ROW_PTR,
  output logic [3:0] CLOCK_CTRL,
  output logic PORT_CTRL,
  output logic [DIV_WIDTH-1:0] DIVIDER_RELOAD,
  output logic [DIV_WIDTH-1:0] DIVIDER_COUNT,
  output logic DIVIDER_TICK,
  output logic [3:0] PULLUP_FIRST,
  output logic [3:0] PULLUP_SECOND,
  output logic [7:0] TIMER_ONE_RELOAD,
  output logic CARRY_TOUCHED,
  output logic SKIP_NEXT
);
  import atd_pkg::*;

  logic rst_meta;
  logic rst_sync;
  atd_op_t op;
  logic [3:0] clock_ctrl_reg, next_clock_ctrl_reg;
  logic port_ctrl_bit, next_port_ctrl_bit;
  logic [DIV_WIDTH-1:0] divider_reload_reg, next_divider_reload_reg;
  logic [DIV_WIDTH-1:0] divider_counter, next_divider_counter;
  logic divider_tick, next_divider_tick;
  logic [3:0] pullup_ctrl_first, next_pullup_ctrl_first;
  logic [3:0] pullup_ctrl_second, next_pullup_ctrl_second;
  logic [7:0] timer_one_reload_reg, next_timer_one_reload_reg;
  logic [3:0] row_ptr, next_row_ptr;
  atd_mem_wr_t mem_wr, next_mem_wr;
  logic [DIV_WIDTH-1:0] bus_word;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  atd_decode u_decode (
    .opcode(INSTR),
    .op(op)
  );

  // B forms the high nibble, A the low one
  assign bus_word = DIV_WIDTH'({REG_B, ACC});

  // Next values of every register touched by the group
  always_comb begin
    next_clock_ctrl_reg = clock_ctrl_reg;
    next_port_ctrl_bit = port_ctrl_bit;
    next_divider_reload_reg = divider_reload_reg;
    next_pullup_ctrl_first = pullup_ctrl_first;
    next_pullup_ctrl_second = pullup_ctrl_second;
    next_timer_one_reload_reg = timer_one_reload_reg;
    next_row_ptr = ROW_LOAD ? ROW_IN : row_ptr;
    next_mem_wr = '0;
    // Free-running down counter, reloaded on wrap
    next_divider_tick = 1'b0;
    if (divider_counter == '0) begin
      next_divider_counter = divider_reload_reg;
      next_divider_tick = 1'b1;
    end else begin
      next_divider_counter = divider_counter - DIV_WIDTH'(`ATD_ONE_DIV);
    end
    // one cycle each: every op finishes in this edge
    if (INSTR_VALID) begin
      case (op)
        ATD_CLOCK: begin
          next_clock_ctrl_reg = ACC;
        end
        ATD_PORT: begin
          next_port_ctrl_bit = ACC[0];
        end
        ATD_DIV: begin
          next_divider_reload_reg = bus_word;
          next_divider_counter = bus_word;
          next_divider_tick = 1'b0;
        end
        ATD_PU0: begin
          next_pullup_ctrl_first = ACC;
        end
        ATD_PU1: begin
          next_pullup_ctrl_second = ACC;
        end
        ATD_TMR1: begin
          next_timer_one_reload_reg = {REG_B, ACC};
        end
        ATD_STORE: begin
          next_mem_wr.we = 1'b1;
          next_mem_wr.addr = {row_ptr, COL_IN};
          next_mem_wr.data = ACC;
          next_row_ptr = row_ptr ^ INSTR[`ATD_IMM_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Registers only; values come from the block above
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      clock_ctrl_reg <= `ATD_NIBBLE_RESET;
      port_ctrl_bit <= `ATD_BIT_RESET;
      divider_reload_reg <= '0;
      divider_counter <= '0;
      divider_tick <= 1'b0;
      pullup_ctrl_first <= `ATD_NIBBLE_RESET;
      pullup_ctrl_second <= `ATD_NIBBLE_RESET;
      timer_one_reload_reg <= `ATD_BYTE_RESET;
      row_ptr <= `ATD_NIBBLE_RESET;
      mem_wr <= '0;
    end else begin
      clock_ctrl_reg <= next_clock_ctrl_reg;
      port_ctrl_bit <= next_port_ctrl_bit;
      divider_reload_reg <= next_divider_reload_reg;
      divider_counter <= next_divider_counter;
      divider_tick <= next_divider_tick;
      pullup_ctrl_first <= next_pullup_ctrl_first;
      pullup_ctrl_second <= next_pullup_ctrl_second;
      timer_one_reload_reg <= next_timer_one_reload_reg;
      row_ptr <= next_row_ptr;
      mem_wr <= next_mem_wr;
    end
  end

  // Outputs straight from flops
  assign MEM_WR = mem_wr;
  assign ROW_PTR = row_ptr;
  assign CLOCK_CTRL = clock_ctrl_reg;
  assign PORT_CTRL = port_ctrl_bit;
  assign DIVIDER_RELOAD = divider_reload_reg;
  assign DIVIDER_COUNT = divider_counter;
  assign DIVIDER_TICK = divider_tick;
  assign PULLUP_FIRST = pullup_ctrl_first;
  assign PULLUP_SECOND = pullup_ctrl_second;
  assign TIMER_ONE_RELOAD = timer_one_reload_reg;
  // group never alters carry nor skips
  assign CARRY_TOUCHED = 1'b0;
  assign SKIP_NEXT = 1'b0;
endmodule

// *** include/atd_defines.svh ***
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

// Opcode values of the decoded group (10-bit words)
`define ATD_OP_CLOCK_CTRL 10'h216
`define ATD_OP_PORT_BIT 10'h2AA
`define ATD_OP_DIVIDER 10'h235
`define ATD_OP_PULLUP_FIRST 10'h22D
`define ATD_OP_PULLUP_SECOND 10'h22E
`define ATD_OP_TIMER_ONE 10'h23F
// Store-and-flip: upper six bits fixed, low four are the immediate
`define ATD_OP_STORE_FLIP_HI 6'h2B
`define ATD_OP_HI_MSB 9
`define ATD_OP_HI_LSB 4
`define ATD_IMM_MSB 3
// Reset values of the loaded registers, then the divider count-down step
`define ATD_NIBBLE_RESET 4'h0
`define ATD_BYTE_RESET 8'h00
`define ATD_BIT_RESET 1'h0
`define ATD_ONE_DIV 8'h01

`endif

// *** include/atd_pkg.sv ***
package atd_pkg;
  // Operation selected by the decoder
  typedef enum logic [2:0] {
    ATD_NONE = 3'b000,
    ATD_CLOCK = 3'b001,
    ATD_PORT = 3'b010,
    ATD_DIV = 3'b011,
    ATD_PU0 = 3'b100,
    ATD_PU1 = 3'b101,
    ATD_TMR1 = 3'b110,
    ATD_STORE = 3'b111
  } atd_op_t;

  // Memory write request toward data RAM
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [3:0] data;
  } atd_mem_wr_t;
endpackage

// *** design/atd_decode.sv ***
`include "atd_defines.svh"

// Pure opcode classifier for the transfer group
module atd_decode (
  input wire logic [9:0] opcode,
  output atd_pkg::atd_op_t op
);
  import atd_pkg::*;

  // Exact compares first; store-and-flip matches a 6-bit prefix
  always_comb begin
    if (opcode == `ATD_OP_CLOCK_CTRL) begin
      op = ATD_CLOCK;
    end else if (opcode == `ATD_OP_PORT_BIT) begin
      op = ATD_PORT;
    end else if (opcode == `ATD_OP_DIVIDER) begin
      op = ATD_DIV;
    end else if (opcode == `ATD_OP_PULLUP_FIRST) begin
      op = ATD_PU0;
    end else if (opcode == `ATD_OP_PULLUP_SECOND) begin
      op = ATD_PU1;
    end else if (opcode == `ATD_OP_TIMER_ONE) begin
      op = ATD_TMR1;
    end else if (opcode[`ATD_OP_HI_MSB:`ATD_OP_HI_LSB] ==
                 `ATD_OP_STORE_FLIP_HI) begin
      op = ATD_STORE;
    end else begin
      op = ATD_NONE;
    end
  end
endmodule

// *** testbench/atd_core_properties.sv ***
// Watches the transfer group at the core's ports
module atd_core_chk #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic INSTR_VALID,
  input wire logic [9:0] INSTR,
  input wire logic [3:0] ACC,
  input wire logic [3:0] REG_B,
  input wire logic [3:0] COL_IN,
  input atd_pkg::atd_mem_wr_t MEM_WR,
  input wire logic [3:0] ROW_PTR,
  input wire logic [3:0] CLOCK_CTRL,
  input wire logic PORT_CTRL,
  input wire logic [DIV_WIDTH-1:0] DIVIDER_RELOAD,
  input wire logic [DIV_WIDTH-1:0] DIVIDER_COUNT,
  input wire logic [3:0] PULLUP_FIRST,
  input wire logic [3:0] PULLUP_SECOND,
  input wire logic [7:0] TIMER_ONE_RELOAD,
  input wire logic CARRY_TOUCHED,
  input wire logic SKIP_NEXT
);
  timeunit 1ns;
  timeprecision 100ps;
  import atd_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire logic st = INSTR_VALID && INSTR[9:4] == 6'h2B;
  // Each opcode lands its source one cycle later
  chk_clock_copy: assert property (INSTR_VALID && INSTR == 10'h216
    |=> CLOCK_CTRL == $past(ACC)) else $error("clock ctrl wrong");
  chk_port_bit: assert property (INSTR_VALID && INSTR == 10'h2AA
    |=> PORT_CTRL == $past(ACC[0])) else $error("port bit wrong");
  chk_divider_pair: assert property (INSTR_VALID && INSTR == 10'h235
    |=> DIVIDER_RELOAD == {$past(REG_B), $past(ACC)})
    else $error("divider reload wrong");
  chk_divider_live: assert property (INSTR_VALID && INSTR == 10'h235
    |=> DIVIDER_COUNT == DIVIDER_RELOAD) else $error("counter not loaded");
  chk_pullup_first: assert property (INSTR_VALID && INSTR == 10'h22D
    |=> PULLUP_FIRST == $past(ACC)) else $error("pull-up first wrong");
  chk_pullup_second: assert property (INSTR_VALID && INSTR == 10'h22E
    |=> PULLUP_SECOND == $past(ACC)) else $error("pull-up second wrong");
  chk_timer_reload: assert property (INSTR_VALID && INSTR == 10'h23F
    |=> TIMER_ONE_RELOAD == {$past(REG_B), $past(ACC)})
    else $error("timer reload wrong");
  chk_row_flip: assert property (st
    |=> ROW_PTR == ($past(ROW_PTR) ^ $past(INSTR[3:0])))
    else $error("row flip wrong");
  chk_store_old_row: assert property (st |=> MEM_WR.we
    && MEM_WR.addr == {$past(ROW_PTR), $past(COL_IN)}
    && MEM_WR.data == $past(ACC)) else $error("store wrong");
  chk_no_flags: assert property (!CARRY_TOUCHED && !SKIP_NEXT)
    else $error("carry or skip touched");
  cover property (st);
  cover property (INSTR_VALID && INSTR == 10'h235);
  cover property (INSTR_VALID && INSTR == 10'h2AA);
endmodule

bind atd_core atd_core_chk #(.DIV_WIDTH(DIV_WIDTH)) u_atd_core_chk (.*);

// *** testbench/test_atd_core.sv ***
module test_atd_core;
  timeunit 1ns;
  timeprecision 100ps;
  import atd_pkg::*;
  logic CLK = 0, ARST_N = 0, INSTR_VALID = 0, ROW_LOAD = 0;
  logic [9:0] INSTR = 0;
  logic [3:0] ACC = 0, REG_B = 0, ROW_IN = 0, COL_IN = 0;
  atd_mem_wr_t MEM_WR;
  logic [3:0] ROW_PTR, CLOCK_CTRL, PULLUP_FIRST, PULLUP_SECOND;
  logic [7:0] DIVIDER_RELOAD, DIVIDER_COUNT, TIMER_ONE_RELOAD;
  logic PORT_CTRL, DIVIDER_TICK, CARRY_TOUCHED, SKIP_NEXT;
  int err_total = 0, compares = 0;
  logic [3:0] v, r;
  atd_core u_atd_core (.*);
  // 125 MHz clock
  initial begin
    forever #4 CLK = ~CLK;
  end
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Holds valid up so calls run back to back
  task automatic ex(input logic [9:0] op, input logic [3:0] a, b);
    @(posedge CLK);
    INSTR_VALID <= 1;
    INSTR <= op;
    ACC <= a;
    REG_B <= b;
    COL_IN <= ~a;
  endtask
  // Last taken result is settled just after this edge
  task automatic idle;
    @(posedge CLK);
    INSTR_VALID <= 0;
    #1;
  endtask
  task automatic t_nibble;
    for (int k = 0; k < 2; k++) begin
      v = k ? 4'hA : 4'h5;
      ex(10'h216, v, 4'hF);
      ex(10'h2AA, ~v, 4'hF);
      ex(10'h22D, v + 4'h1, 4'hF);
      ex(10'h22E, v + 4'h2, 4'hF);
      idle;
      chk(CLOCK_CTRL, v);
      chk(PORT_CTRL, {~v[0]});
      chk(PULLUP_FIRST, v + 4'h1);
      chk(PULLUP_SECOND, v + 4'h2);
    end
    $display("nibble test done");
  endtask
  task automatic t_pairs;
    ex(10'h235, 4'h2, 4'h1);
    idle;
    chk(DIVIDER_RELOAD, 8'h12);
    chk(DIVIDER_COUNT, 8'h12);
    ex(10'h23F, 4'hC, 4'h7);
    idle;
    chk(TIMER_ONE_RELOAD, 8'h7C);
    chk(DIVIDER_RELOAD, 8'h12);
    // Short reload so the running counter wraps within a few edges
    ex(10'h235, 4'h2, 4'h0);
    idle;
    chk(DIVIDER_COUNT, 8'h02);
    chk(DIVIDER_TICK, 1'b0);
    repeat (3) @(posedge CLK);
    #1;
    chk(DIVIDER_COUNT, 8'h02);
    chk(DIVIDER_TICK, 1'b1);
    $display("pair test done");
  endtask
  task automatic t_store;
    @(posedge CLK);
    ROW_LOAD <= 1;
    ROW_IN <= 4'h3;
    @(posedge CLK);
    ROW_LOAD <= 0;
    r = 4'h3;
    for (int j = 0; j < 16; j++) begin
      ex({6'h2B, 4'(j)}, 4'(j), 4'h0);
      idle;
      chk(MEM_WR, {1'b1, r, ~4'(j), 4'(j)});
      r = r ^ 4'(j);
      chk(ROW_PTR, r);
    end
    $display("store test done");
  endtask
  task automatic t_refuse;
    ex(10'h217, 4'h3, 4'h3);
    ex(10'h2AB, 4'h0, 4'h0);
    ex(10'h2A5, 4'h6, 4'h6);
    idle;
    chk(CLOCK_CTRL, 4'hA);
    chk(PORT_CTRL, 1'b1);
    chk(ROW_PTR, r);
    chk(MEM_WR.we, 1'b0);
    chk({CARRY_TOUCHED, SKIP_NEXT}, 2'b00);
    $display("refuse test done");
  endtask
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run is under 200 cycles, so 20 us means a hang
  initial begin
    #20000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1;
    repeat (3) @(posedge CLK);
    t_nibble;
    t_pairs;
    t_store;
    t_refuse;
    give_verdict;
  end
endmodule
